// File: design/field_memory_pkg.sv
`default_nettype none
package field_memory_pkg;
    // ----------------------------------------------------------------
    // array geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W    = 18;
    localparam int DATA_W    = 8;
    localparam int MEM_WORDS = 262144;

    // ----------------------------------------------------------------
    // write staging and input buffer
    // ----------------------------------------------------------------
    localparam int STAGE_AW    = 7;
    localparam int STAGE_DEPTH = 128;
    localparam int CNT_W       = 8;
    localparam int BUF_DEPTH   = 2;
    localparam int BUF_CNT_W   = 2;

    // entries held back from the array until a write clear flushes them
    localparam logic [CNT_W-1:0]     WRITE_LAG  = 8'h46;
    localparam logic [CNT_W-1:0]     STAGE_FULL = 8'h80;
    localparam logic [CNT_W-1:0]     CNT_ZERO   = 8'h00;
    localparam logic [CNT_W-1:0]     CNT_ONE    = 8'h01;
    localparam logic [BUF_CNT_W-1:0] BUF_FULL   = 2'h2;
    localparam logic [BUF_CNT_W-1:0] BUF_ZERO   = 2'h0;
    localparam logic [BUF_CNT_W-1:0] BUF_ONE    = 2'h1;

    // ----------------------------------------------------------------
    // reset values and steps
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0]   PTR_CLEAR  = 18'h0_0000;
    localparam logic [ADDR_W-1:0]   PTR_STEP   = 18'h0_0001;
    localparam logic [DATA_W-1:0]   BYTE_RESET = 8'h00;
    localparam logic [STAGE_AW-1:0] STAGE_STEP = 7'h01;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] byte_t;
endpackage
`default_nettype wire

// File: design/serial_field_memory_fifo.sv
// Summary of operation
// - first write clock with clear zeroes pointer
// - write clear cycle ignores both write gates
// - write clear flushes staged bytes into array
// - advance gate high captures byte, bumps pointer
// - advance gate low holds pointer, drops data
// - mask gate low skips store, pointer advances
// - first read clock with clear zeroes pointer
// - read clear cycle ignores both read gates
// - read advance gate high shifts out, bumps pointer
// - output byte keeps written polarity, three-state
// - drive gate enables outputs, pointer still advances
// - static logic, port clocks may stop indefinitely
// - read clear within 70 writes gives old field
`timescale 1ns/1ps
`default_nettype none
module serial_field_memory_fifo
    import field_memory_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    input  wire logic              input_shift_clock,
    input  wire logic              input_pointer_clear,
    input  wire logic              input_advance_gate,
    input  wire logic              write_mask_gate,
    input  wire logic [DATA_W-1:0] input_byte,
    input  wire logic              output_shift_clock,
    input  wire logic              output_pointer_clear,
    input  wire logic              output_advance_gate,
    input  wire logic              output_drive_gate,
    output var  logic [DATA_W-1:0] output_byte,
    output var  logic              output_byte_oe
);

    // ----------------------------------------------------------------
    // edge decode
    // ----------------------------------------------------------------
    // port clocks are sampled, so a stopped clock simply yields no edge
    function automatic logic rise(input logic prev, input logic now);
        rise = now & ~prev;
    endfunction

    byte_t             mem [MEM_WORDS];
    addr_t             stage_addr  [STAGE_DEPTH];
    byte_t             stage_data  [STAGE_DEPTH];
    logic              stage_store [STAGE_DEPTH];
    addr_t             buf_addr_q  [BUF_DEPTH];
    byte_t             buf_data_q  [BUF_DEPTH];
    logic              buf_store_q [BUF_DEPTH];

    logic              wclk_q, wclk_d;
    logic              rclk_q, rclk_d;
    logic              wclr_q, wclr_d;
    logic              rclr_q, rclr_d;
    addr_t             wr_ptr_q, wr_ptr_d;
    addr_t             rd_ptr_q, rd_ptr_d;
    byte_t             out_q, out_d;
    logic              oe_q, oe_d;
    logic              buf_wi_q, buf_wi_d;
    logic              buf_ri_q, buf_ri_d;
    logic [BUF_CNT_W-1:0] buf_cnt_q, buf_cnt_d;
    logic [STAGE_AW-1:0]  st_wi_q, st_wi_d;
    logic [STAGE_AW-1:0]  st_ri_q, st_ri_d;
    logic [CNT_W-1:0]     st_cnt_q, st_cnt_d;
    logic [CNT_W-1:0]     flush_q, flush_d;

    logic              w_edge;
    logic              r_edge;
    logic              w_clear;
    logic              r_clear;
    logic              buf_push;
    logic              buf_ready;
    logic              buf_valid;
    logic              st_push;
    logic              st_ready;
    logic              commit;

    // ----------------------------------------------------------------
    // pin sampling
    // ----------------------------------------------------------------
    always_comb
    begin
        wclk_d  = input_shift_clock;
        rclk_d  = output_shift_clock;
        w_edge  = rise(wclk_q, input_shift_clock);
        r_edge  = rise(rclk_q, output_shift_clock);
        wclr_d  = w_edge ? input_pointer_clear : wclr_q;
        rclr_d  = r_edge ? output_pointer_clear : rclr_q;
        // only the first edge that sees the clear high acts on it
        w_clear = w_edge & input_pointer_clear & ~wclr_q;
        r_clear = r_edge & output_pointer_clear & ~rclr_q;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wclk_q <= 1'b1;   // a clock parked high gives no false rise
            rclk_q <= 1'b1;
            wclr_q <= 1'b0;
            rclr_q <= 1'b0;
        end
        else if (clk_en)
        begin
            wclk_q <= wclk_d;
            rclk_q <= rclk_d;
            wclr_q <= wclr_d;
            rclr_q <= rclr_d;
        end
    end

    // ----------------------------------------------------------------
    // write port
    // ----------------------------------------------------------------
    always_comb
    begin
        wr_ptr_d = wr_ptr_q;
        buf_push = 1'b0;
        if (w_clear)
        begin
            wr_ptr_d = PTR_CLEAR;
        end
        else if (w_edge && input_advance_gate && buf_ready)
        begin
            buf_push = 1'b1;
            wr_ptr_d = wr_ptr_q + PTR_STEP;
        end
        // gate low: no capture, pointer holds
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr_q <= PTR_CLEAR;
        end
        else if (clk_en)
        begin
            wr_ptr_q <= wr_ptr_d;
        end
    end

    // ----------------------------------------------------------------
    // two-entry input buffer
    // ----------------------------------------------------------------
    // a full staging area stalls the drain; a full buffer stalls capture
    always_comb
    begin
        buf_valid = (buf_cnt_q != BUF_ZERO);
        buf_ready = (buf_cnt_q != BUF_FULL);
        st_push   = buf_valid & st_ready;
        buf_wi_d  = buf_push ? ~buf_wi_q : buf_wi_q;
        buf_ri_d  = st_push ? ~buf_ri_q : buf_ri_q;
        buf_cnt_d = buf_cnt_q;
        if (buf_push && !st_push)
        begin
            buf_cnt_d = buf_cnt_q + BUF_ONE;
        end
        else if (!buf_push && st_push)
        begin
            buf_cnt_d = buf_cnt_q - BUF_ONE;
        end
    end

    generate
        for (genvar i = 0; i < BUF_DEPTH; i++)
        begin : g_buf
            always_ff @(posedge clk_sys or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    buf_addr_q[i]  <= PTR_CLEAR;
                    buf_data_q[i]  <= BYTE_RESET;
                    buf_store_q[i] <= 1'b0;
                end
                else if (clk_en && buf_push && (buf_wi_q == i[0]))
                begin
                    buf_addr_q[i]  <= wr_ptr_q;
                    buf_data_q[i]  <= input_byte;
                    buf_store_q[i] <= write_mask_gate;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            buf_wi_q  <= 1'b0;
            buf_ri_q  <= 1'b0;
            buf_cnt_q <= BUF_ZERO;
        end
        else if (clk_en)
        begin
            buf_wi_q  <= buf_wi_d;
            buf_ri_q  <= buf_ri_d;
            buf_cnt_q <= buf_cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // write staging and commit
    // ----------------------------------------------------------------
    // new bytes lag the array by a fixed count so a late read clear
    // still sees the previous field; a write clear flushes the lag
    always_comb
    begin
        st_ready = (st_cnt_q != STAGE_FULL);
        commit   = (st_cnt_q != CNT_ZERO) &&
                   ((st_cnt_q > WRITE_LAG) || (flush_q != CNT_ZERO));
        st_wi_d  = st_push ? st_wi_q + STAGE_STEP : st_wi_q;
        st_ri_d  = commit ? st_ri_q + STAGE_STEP : st_ri_q;
        st_cnt_d = st_cnt_q;
        if (st_push && !commit)
        begin
            st_cnt_d = st_cnt_q + CNT_ONE;
        end
        else if (!st_push && commit)
        begin
            st_cnt_d = st_cnt_q - CNT_ONE;
        end
        flush_d = flush_q;
        if (w_clear)
        begin
            flush_d = st_cnt_q + {{(CNT_W-BUF_CNT_W){1'b0}}, buf_cnt_q};
            if (commit)
            begin
                flush_d = flush_d - CNT_ONE;
            end
        end
        else if (commit && (flush_q != CNT_ZERO))
        begin
            flush_d = flush_q - CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_wi_q  <= '0;
            st_ri_q  <= '0;
            st_cnt_q <= CNT_ZERO;
            flush_q  <= CNT_ZERO;
        end
        else if (clk_en)
        begin
            st_wi_q  <= st_wi_d;
            st_ri_q  <= st_ri_d;
            st_cnt_q <= st_cnt_d;
            flush_q  <= flush_d;
        end
    end

    // storage carries no reset: contents are undefined until written
    always_ff @(posedge clk_sys)
    begin
        if (clk_en && st_push)
        begin
            stage_addr[st_wi_q]  <= buf_addr_q[buf_ri_q];
            stage_data[st_wi_q]  <= buf_data_q[buf_ri_q];
            stage_store[st_wi_q] <= buf_store_q[buf_ri_q];
        end
        if (clk_en && commit && stage_store[st_ri_q])
        begin
            mem[stage_addr[st_ri_q]] <= stage_data[st_ri_q];
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_ptr_d = rd_ptr_q;
        out_d    = out_q;
        oe_d     = oe_q;
        if (r_clear)
        begin
            rd_ptr_d = PTR_CLEAR;
        end
        else if (r_edge)
        begin
            oe_d = output_drive_gate;
            if (output_advance_gate)
            begin
                out_d    = mem[rd_ptr_q];
                rd_ptr_d = rd_ptr_q + PTR_STEP;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_ptr_q <= PTR_CLEAR;
            out_q    <= BYTE_RESET;
            oe_q     <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_ptr_q <= rd_ptr_d;
            out_q    <= out_d;
            oe_q     <= oe_d;
        end
    end

    assign output_byte    = out_q;
    assign output_byte_oe = oe_q;

endmodule
`default_nettype wire

// File: tb/fm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fm_asserts
    import field_memory_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              sys_rst,
    input wire logic              clk_en,
    input wire logic              output_shift_clock,
    input wire logic              output_pointer_clear,
    input wire logic              output_advance_gate,
    input wire logic              output_drive_gate,
    input wire logic [DATA_W-1:0] output_byte,
    input wire logic              output_byte_oe
);
    // ------------------------------------------------
    // read rise and clear cycle rebuilt from the pins
    // ------------------------------------------------
    logic ck_q;
    logic ck_d;
    logic clr_q;
    logic clr_d;
    logic rise;
    logic rclr;
    assign rise = clk_en & output_shift_clock & ~ck_q;
    assign rclr = rise & output_pointer_clear & ~clr_q;
    always_comb
    begin
        ck_d  = clk_en ? output_shift_clock : ck_q;
        clr_d = rise ? output_pointer_clear : clr_q;
    end
    // a port clock already high at release is no rise
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ck_q  <= 1'h1;
            clr_q <= 1'h0;
        end
        else
        begin
            ck_q  <= ck_d;
            clr_q <= clr_d;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_oe_on;
        rise && !rclr && output_drive_gate |=> output_byte_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("oe low after driven read");
    property p_oe_off;
        rise && !rclr && !output_drive_gate |=> !output_byte_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe high, drive low");
    property p_clr_hold;
        rclr |=> $stable(output_byte) && $stable(output_byte_oe);
    endproperty
    a_clr_hold: assert property (p_clr_hold) else $error("clear moved outputs");
    property p_adv_hold;
        rise && !rclr && !output_advance_gate |=> $stable(output_byte);
    endproperty
    a_adv_hold: assert property (p_adv_hold) else $error("byte moved, advance low");
    property p_idle_hold;
        !rise |=> $stable(output_byte) && $stable(output_byte_oe);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("outputs moved, no rise");
    property p_oe_lasts;
        rise && !rclr && output_drive_gate |=> output_byte_oe [*2];
    endproperty
    a_oe_lasts: assert property (p_oe_lasts) else $error("oe dropped early");
    property p_byte_cause;
        $changed(output_byte) |-> $past(rise) && !$past(rclr) && $past(output_advance_gate);
    endproperty
    a_byte_cause: assert property (p_byte_cause) else $error("byte moved uncaused");
    property p_oe_cause;
        $changed(output_byte_oe) |-> $past(rise) && !$past(rclr);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("oe moved uncaused");
endmodule
bind serial_field_memory_fifo fm_asserts fm_asserts_inst (
    .clk_sys, .sys_rst, .clk_en, .output_shift_clock, .output_pointer_clear,
    .output_advance_gate, .output_drive_gate, .output_byte, .output_byte_oe
);
`default_nettype wire

// File: tb/serial_field_memory_fifo_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_field_memory_fifo_tb_top
    import field_memory_pkg::*;
;
    logic  clk_sys, sys_rst, clk_en, output_byte_oe;
    logic  input_shift_clock, input_pointer_clear, input_advance_gate, write_mask_gate;
    logic  output_shift_clock, output_pointer_clear, output_advance_gate, output_drive_gate;
    byte_t input_byte, output_byte;
    int    errors, total_checks;
    serial_field_memory_fifo serial_field_memory_fifo_inst (.clk_sys, .sys_rst, .clk_en,
        .input_shift_clock, .input_pointer_clear, .input_advance_gate, .write_mask_gate,
        .input_byte, .output_shift_clock, .output_pointer_clear, .output_advance_gate,
        .output_drive_gate, .output_byte, .output_byte_oe);
    vid_ctrl vid_ctrl_inst (.clk_sys, .input_shift_clock, .input_pointer_clear,
        .input_advance_gate, .write_mask_gate, .input_byte, .output_shift_clock,
        .output_pointer_clear, .output_advance_gate, .output_drive_gate);
    task automatic chk(input string what, input byte_t seen, input byte_t exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic t_init;
        chk("oe", {7'h00, output_byte_oe}, 8'h00);
        vid_ctrl_inst.wr(1'h1, 1'h0, 1'h0, 8'h00);
        vid_ctrl_inst.rd(1'h1, 1'h0, 1'h0);
        repeat (80)
        begin
            vid_ctrl_inst.wr(1'h0, 1'h1, 1'h1, 8'h5a);
            // read side idles without advance: only 10 of the 80 cells reach the array here
            vid_ctrl_inst.rd(1'h0, 1'h0, 1'h0);
        end
        vid_ctrl_inst.wr(1'h1, 1'h1, 1'h1, 8'hee);
        vid_ctrl_inst.rd(1'h1, 1'h1, 1'h1);
        chk("oe", {7'h00, output_byte_oe}, 8'h00);
        // clears must fall for one port clock before the next one counts
        repeat (2)
        begin
            vid_ctrl_inst.wr(1'h0, 1'h0, 1'h0, 8'h00);
            vid_ctrl_inst.rd(1'h0, 1'h0, 1'h0);
        end
        $display("init done");
    endtask
    task automatic t_old;
        for (int i = 0; i < 100; i++)
        begin
            if (i % 10 == 5)
                vid_ctrl_inst.wr(1'h0, 1'h0, 1'h1, 8'h00);
            vid_ctrl_inst.wr(1'h0, 1'h1, 1'h1, 8'(i + 1));
        end
        repeat (600) vid_ctrl_inst.wr(1'h0, 1'h0, 1'h0, 8'h00);
        vid_ctrl_inst.wr(1'h1, 1'h1, 1'h1, 8'hee);
        for (int i = 0; i < 10; i++)
            vid_ctrl_inst.wr(1'h0, 1'h1, 1'h1, ~8'(i + 1));
        vid_ctrl_inst.rd(1'h1, 1'h1, 1'h0);
        for (int i = 0; i < 100; i++)
        begin
            if (i == 50)
            begin
                vid_ctrl_inst.rd(1'h0, 1'h0, 1'h1);
                chk("hold", output_byte, 8'(i));
            end
            vid_ctrl_inst.rd(1'h0, 1'h1, 1'h1);
            chk("old", output_byte, 8'(i + 1));
        end
        $display("old field done");
    endtask
    task automatic t_mask;
        for (int i = 10; i < 100; i++)
            vid_ctrl_inst.wr(1'h0, 1'h1, !i[0], ~8'(i + 1));
        vid_ctrl_inst.wr(1'h1, 1'h0, 1'h0, 8'h00);
        repeat (600)
        begin
            vid_ctrl_inst.wr(1'h0, 1'h0, 1'h0, 8'h00);
            vid_ctrl_inst.rd(1'h0, 1'h0, 1'h1);
        end
        vid_ctrl_inst.rd(1'h1, 1'h1, 1'h0);
        chk("oe", {7'h00, output_byte_oe}, 8'h01);
        for (int i = 0; i < 100; i++)
        begin
            // parked port clocks must lose nothing
            // a read clock while the enable is low must leave no trace
            if (i == 60)
            begin
                @(posedge clk_sys);
                clk_en <= 1'h0;
                vid_ctrl_inst.rd(1'h0, 1'h1, 1'h1);
                chk("freeze", output_byte, 8'(i));
                @(posedge clk_sys);
                clk_en <= 1'h1;
                repeat (200) @(posedge clk_sys);
            end
            vid_ctrl_inst.rd(1'h0, 1'h1, i != 20);
            if (i == 20)
                chk("oe", {7'h00, output_byte_oe}, 8'h00);
            else
                chk("new", output_byte, (i < 10 || !i[0]) ? ~8'(i + 1) : 8'(i + 1));
        end
        $display("new field done");
    endtask
    initial
    begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial
    begin
        errors = 0;
        total_checks = 0;
        sys_rst = 1'h1;
        clk_en = 1'h1;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'h0;
        @(posedge clk_sys);
        t_init;
        t_old;
        t_mask;
        wrap_up;
    end
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        errors++;
        wrap_up;
    end
endmodule
`default_nettype wire

// File: tb/vid_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module vid_ctrl
    import field_memory_pkg::*;
(
    input  wire logic clk_sys,
    output var  logic input_shift_clock,
    output var  logic input_pointer_clear,
    output var  logic input_advance_gate,
    output var  logic write_mask_gate,
    output var byte_t input_byte,
    output var  logic output_shift_clock,
    output var  logic output_pointer_clear,
    output var  logic output_advance_gate,
    output var  logic output_drive_gate
);
    initial
    begin
        {input_shift_clock, input_pointer_clear, input_advance_gate, write_mask_gate} = 4'h0;
        {output_shift_clock, output_pointer_clear, output_advance_gate, output_drive_gate} = 4'h0;
        input_byte = 8'h00;
    end
    // one port clock: low a cycle, high with gates held until sampled
    task automatic wr(input logic c, input logic a, input logic k, input byte_t d);
        @(posedge clk_sys);
        input_shift_clock <= 1'h0;
        input_pointer_clear <= c;
        input_advance_gate <= a;
        write_mask_gate <= k;
        // unused data toggles, so a stray capture shows
        input_byte <= a ? d : ~input_byte;
        @(posedge clk_sys);
        input_shift_clock <= 1'h1;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic c, input logic a, input logic e);
        @(posedge clk_sys);
        output_shift_clock <= 1'h0;
        output_pointer_clear <= c;
        output_advance_gate <= a;
        output_drive_gate <= e;
        @(posedge clk_sys);
        output_shift_clock <= 1'h1;
        @(posedge clk_sys);
        #1;
    endtask
endmodule
`default_nettype wire
